/* core/arft_top.sv */
// auxiliary relay function selection, in-out timer and damper/lube sequencing
`default_nettype none
module arft_top #(
    parameter int unsigned TICK_CYCLES = arft_pkg::TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [6:0]  multi_function_inputs,
    input  wire logic        start_request,
    input  wire logic        drive_stopped,
    input  wire logic [15:0] speed_ref,
    input  wire logic [15:0] out_freq,
    input  wire logic [15:0] out_current,
    input  wire logic [11:0] voltage_analog_input,
    input  wire logic        current_input_loss_trip,
    output logic      [3:0]  aux_relay,
    output logic             motor_start,
    output logic             damper_fault
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0]            tsel;
        arft_pkg::arft_tmode_t tmode;
        logic                  tnc;
        arft_pkg::arft_dmode_t dmode;
        logic                  dsw_en;
        logic [2:0]            dsw_sel;
        logic [12:0]           tset;
        logic [15:0]           dtime;
        logic [3:0][3:0]       rsel;
        logic [15:0]           fdt_freq;
        logic [15:0]           fdt_band;
        logic [15:0]           ol_level;
        logic [15:0]           ol_time;
        logic [6:0]            sync1;
        logic [6:0]            sync2;
        logic [31:0]           tick_cnt;
        logic                  tick;
        logic [12:0]           tcnt;
        logic                  tout;
        logic                  tprev;
        logic [15:0]           olcnt;
        logic                  olflag;
        logic                  above;
        arft_pkg::arft_seq_t   seq;
        logic [15:0]           scnt;
        logic                  damper_rly;
        logic                  refill;
        logic                  dfault;
        logic                  start;
        logic                  latch;
        logic [3:0]            aux;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
    } arft_state_t;

    arft_state_t st;
    arft_state_t next_st;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic arft_state_t arft_reset_val();
        arft_state_t s;
        s       = '0;
        s.tset  = arft_pkg::TIMER_SET_RST;
        s.dtime = arft_pkg::DMPR_TIME_RST;
        return s;
    endfunction

    function automatic logic [15:0] arft_absdiff(input logic [15:0] a, input logic [15:0] b);
        return (a >= b) ? a - b : b - a;
    endfunction

    function automatic logic arft_pick(input logic [3:0] code, input logic [14:0] fn);
        logic r;
        r = 1'b0;
        if (code <= 4'(arft_pkg::FN_LOSS_LATCH))
        begin
            r = fn[code];
        end
        return r;
    endfunction

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    logic        trig;
    logic        rise;
    logic        tdone;
    logic        sdone;
    logic        dsw_gate;
    logic [15:0] half;
    logic [14:0] fn;
    logic        setup;
    logic        wr;
    logic [31:0] rd;
    logic        hit;

    always_comb
    begin
        next_st = st;

        // input sync; only stage two is looked at
        next_st.sync1 = multi_function_inputs;
        next_st.sync2 = st.sync1;

        // free-running second tick; phase is not aligned to events, so a
        // timed interval can be short by up to one tick
        next_st.tick = 1'b0;
        if (st.tick_cnt >= 32'(TICK_CYCLES - 1))
        begin
            next_st.tick_cnt = '0;
            next_st.tick     = 1'b1;
        end
        else
        begin
            next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
        end

        // ---------------- in-out timer ----------------
        trig = 1'b0;
        if (st.tsel < 3'(arft_pkg::NUM_INPUTS))
        begin
            trig = st.sync2[st.tsel] ^ st.tnc;
        end
        rise          = trig & ~st.tprev;
        tdone         = st.tcnt >= st.tset;
        next_st.tprev = trig;
        case (st.tmode)
            arft_pkg::TM_ON_DELAY:
            begin
                if (!trig)
                begin
                    next_st.tcnt = '0;
                    next_st.tout = 1'b0;
                end
                else if (tdone)
                    next_st.tout = 1'b1;
                else if (st.tick)
                    next_st.tcnt = st.tcnt + 13'h0001;
            end
            arft_pkg::TM_OFF_DELAY:
            begin
                if (trig)
                begin
                    next_st.tcnt = '0;
                    next_st.tout = 1'b1;
                end
                else if (st.tout && tdone)
                    next_st.tout = 1'b0;
                else if (st.tout && st.tick)
                    next_st.tcnt = st.tcnt + 13'h0001;
            end
            arft_pkg::TM_ONE_PULSE:
            begin
                // retrigger ignored while the pulse runs
                if (st.tout)
                begin
                    if (tdone)
                        next_st.tout = 1'b0;
                    else if (st.tick)
                        next_st.tcnt = st.tcnt + 13'h0001;
                end
                else if (rise)
                begin
                    next_st.tout = 1'b1;
                    next_st.tcnt = '0;
                end
            end
            arft_pkg::TM_SYMM:
            begin
                // with nc polarity this runs until the contact closes
                if (!trig)
                begin
                    next_st.tout = 1'b0;
                    next_st.tcnt = '0;
                end
                else if (rise)
                begin
                    next_st.tout = 1'b1;
                    next_st.tcnt = '0;
                end
                else if (tdone)
                begin
                    next_st.tout = ~st.tout;
                    next_st.tcnt = '0;
                end
                else if (st.tick)
                    next_st.tcnt = st.tcnt + 13'h0001;
            end
            default:
            begin
                next_st.tout = 1'b0;
            end
        endcase

        // ---------------- frequency detection ----------------
        half = {1'b0, st.fdt_band[15:1]};
        if (out_freq >= st.fdt_freq)
            next_st.above = 1'b1;
        else if (({1'b0, out_freq} + {1'b0, half}) < {1'b0, st.fdt_freq})
            next_st.above = 1'b0;

        // ---------------- overload warning ----------------
        if (out_current > st.ol_level)
        begin
            if (st.olcnt >= st.ol_time)
                next_st.olflag = 1'b1;
            else if (st.tick)
                next_st.olcnt = st.olcnt + 16'h0001;
        end
        else
        begin
            next_st.olcnt  = '0;
            next_st.olflag = 1'b0;
        end

        // ---------------- damper / lube sequence ----------------
        sdone    = st.scnt >= st.dtime;
        dsw_gate = (st.dmode == arft_pkg::DM_DAMPER) && st.dsw_en;
        case (st.seq)
            arft_pkg::SEQ_IDLE:
            begin
                next_st.refill = 1'b0;
                if (start_request)
                begin
                    next_st.scnt = '0;
                    if (st.dmode == arft_pkg::DM_DAMPER)
                    begin
                        next_st.damper_rly = 1'b1;
                        next_st.seq        = arft_pkg::SEQ_WAIT;
                    end
                    else if (st.dmode == arft_pkg::DM_LUBE)
                        next_st.seq = arft_pkg::SEQ_WAIT;
                    else
                        next_st.seq = arft_pkg::SEQ_RUN;
                end
                else if (drive_stopped)
                    next_st.damper_rly = 1'b0;
            end
            arft_pkg::SEQ_WAIT:
            begin
                if (!start_request)
                    next_st.seq = arft_pkg::SEQ_IDLE;
                else if (dsw_gate && st.sync2[st.dsw_sel])
                    next_st.seq = arft_pkg::SEQ_RUN;
                else if (sdone && dsw_gate)
                begin
                    next_st.seq    = arft_pkg::SEQ_FAULT;
                    next_st.dfault = 1'b1;
                end
                else if (sdone)
                begin
                    next_st.seq    = arft_pkg::SEQ_RUN;
                    next_st.scnt   = '0;
                    next_st.refill = (st.dmode == arft_pkg::DM_LUBE);
                end
                else if (st.tick)
                    next_st.scnt = st.scnt + 16'h0001;
            end
            arft_pkg::SEQ_RUN:
            begin
                if (!start_request)
                    next_st.seq = arft_pkg::SEQ_IDLE;
                else if (st.refill && sdone)
                    next_st.refill = 1'b0;
                else if (st.refill && st.tick)
                    next_st.scnt = st.scnt + 16'h0001;
            end
            arft_pkg::SEQ_FAULT:
            begin
                // fault holds until the start request is withdrawn
                if (!start_request)
                begin
                    next_st.seq    = arft_pkg::SEQ_IDLE;
                    next_st.dfault = 1'b0;
                end
            end
            default:
            begin
                next_st.seq = arft_pkg::SEQ_IDLE;
            end
        endcase
        next_st.start = (next_st.seq == arft_pkg::SEQ_RUN);

        // ---------------- apb slave ----------------
        setup = psel && !penable;
        wr    = psel && penable && st.pready && pwrite;
        hit   = 1'b1;
        rd    = '0;
        case (paddr)
            arft_pkg::ADDR_CTRL:
            begin
                rd[arft_pkg::CTRL_TSEL_LSB +: 3]  = st.tsel;
                rd[arft_pkg::CTRL_TMODE_LSB +: 2] = st.tmode;
                rd[arft_pkg::CTRL_TNC_BIT]        = st.tnc;
                rd[arft_pkg::CTRL_DMODE_LSB +: 2] = st.dmode;
                rd[arft_pkg::CTRL_DSW_EN_BIT]     = st.dsw_en;
                rd[arft_pkg::CTRL_DSW_LSB +: 3]   = st.dsw_sel;
            end
            arft_pkg::ADDR_TIMER_SET: rd[12:0] = st.tset;
            arft_pkg::ADDR_DMPR_TIME: rd[15:0] = st.dtime;
            arft_pkg::ADDR_RELAY_SEL: rd[15:0] = st.rsel;
            arft_pkg::ADDR_FREQ_DET:  rd = {st.fdt_band, st.fdt_freq};
            arft_pkg::ADDR_OVERLOAD:  rd = {st.ol_time, st.ol_level};
            arft_pkg::ADDR_STATUS:
            begin
                rd[arft_pkg::ST_AUX_LSB +: 4]  = st.aux;
                rd[arft_pkg::ST_TOUT_BIT]      = st.tout;
                rd[arft_pkg::ST_START_BIT]     = st.start;
                rd[arft_pkg::ST_DFAULT_BIT]    = st.dfault;
                rd[arft_pkg::ST_LATCH_BIT]     = st.latch;
                rd[arft_pkg::ST_SEQ_LSB +: 2]  = st.seq;
            end
            arft_pkg::ADDR_LATCH_CLR: rd = '0;
            default:                  hit = 1'b0;
        endcase
        // one wait-free access phase after each setup
        next_st.pready  = setup;
        next_st.pslverr = setup && !hit;
        if (setup)
            next_st.prdata = (hit && !pwrite) ? rd : '0;
        if (wr && hit)
        begin
            case (paddr)
                arft_pkg::ADDR_CTRL:
                begin
                    next_st.tsel    = pwdata[arft_pkg::CTRL_TSEL_LSB +: 3];
                    next_st.tmode   = arft_pkg::arft_tmode_t'(
                                      pwdata[arft_pkg::CTRL_TMODE_LSB +: 2]);
                    next_st.tnc     = pwdata[arft_pkg::CTRL_TNC_BIT];
                    next_st.dmode   = arft_pkg::arft_dmode_t'(
                                      pwdata[arft_pkg::CTRL_DMODE_LSB +: 2]);
                    next_st.dsw_en  = pwdata[arft_pkg::CTRL_DSW_EN_BIT];
                    next_st.dsw_sel = pwdata[arft_pkg::CTRL_DSW_LSB +: 3];
                end
                arft_pkg::ADDR_TIMER_SET:
                begin
                    // out-of-range settings clamp to the top of the range
                    if (pwdata > 32'(arft_pkg::TIMER_SET_MAX))
                        next_st.tset = arft_pkg::TIMER_SET_MAX;
                    else
                        next_st.tset = pwdata[12:0];
                end
                arft_pkg::ADDR_DMPR_TIME: next_st.dtime = pwdata[15:0];
                arft_pkg::ADDR_RELAY_SEL: next_st.rsel = pwdata[15:0];
                arft_pkg::ADDR_FREQ_DET:
                begin
                    next_st.fdt_freq = pwdata[15:0];
                    next_st.fdt_band = pwdata[arft_pkg::HI_LSB +: 16];
                end
                arft_pkg::ADDR_OVERLOAD:
                begin
                    next_st.ol_level = pwdata[15:0];
                    next_st.ol_time  = pwdata[arft_pkg::HI_LSB +: 16];
                end
                default:
                begin
                end
            endcase
        end

        // loss latch: a trip in the clearing cycle still sets it
        next_st.latch = current_input_loss_trip
                        | (st.latch & ~(wr && paddr == arft_pkg::ADDR_LATCH_CLR
                                        && pwdata[arft_pkg::LATCH_CLR_BIT]));

        // ---------------- relay functions ----------------
        fn                              = '0;
        fn[arft_pkg::FN_REF_REACHED]    = arft_absdiff(speed_ref, out_freq) < half;
        fn[arft_pkg::FN_AT_SETPOINT]    = (arft_absdiff(speed_ref, st.fdt_freq) <= half)
                                          && (arft_absdiff(out_freq, st.fdt_freq) <= half);
        fn[arft_pkg::FN_IN_RANGE]       = arft_absdiff(out_freq, st.fdt_freq) <= half;
        fn[arft_pkg::FN_ABOVE_FREQ]     = st.above;
        fn[arft_pkg::FN_BELOW_FREQ]     = ~st.above;
        fn[arft_pkg::FN_OVERLOAD]       = st.olflag;
        fn[arft_pkg::FN_RUN]            = ~drive_stopped;
        fn[arft_pkg::FN_STOP]           = drive_stopped;
        fn[arft_pkg::FN_DAMPER]         = st.damper_rly;
        fn[arft_pkg::FN_LUBE_ONLY]      = (st.dmode == arft_pkg::DM_LUBE)
                                          && (st.seq == arft_pkg::SEQ_WAIT);
        fn[arft_pkg::FN_LUBE_REFILL]    = fn[arft_pkg::FN_LUBE_ONLY]
                                          || ((st.seq == arft_pkg::SEQ_RUN) && st.refill);
        fn[arft_pkg::FN_TIMER]          = st.tout;
        fn[arft_pkg::FN_VIN_SAT]        = voltage_analog_input == arft_pkg::VIN_FULL;
        fn[arft_pkg::FN_LOSS_LATCH]     = st.latch;
        for (int i = 0; i < arft_pkg::NUM_RELAYS; i++)
        begin
            next_st.aux[i] = arft_pick(st.rsel[i], fn);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= arft_reset_val();
        else
            st <= next_st;
    end

    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = st.pslverr;
    assign aux_relay    = st.aux;
    assign motor_start  = st.start;
    assign damper_fault = st.dfault;
endmodule
`default_nettype wire

/* core/arft_pkg.sv */
// constants and types for the auxiliary relay function timer
`default_nettype none
package arft_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SECOND_NS     = 1_000_000_000;
    localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_TIMER_SET = 12'h004;
    localparam logic [11:0] ADDR_DMPR_TIME = 12'h008;
    localparam logic [11:0] ADDR_RELAY_SEL = 12'h00C;
    localparam logic [11:0] ADDR_FREQ_DET  = 12'h010;
    localparam logic [11:0] ADDR_OVERLOAD  = 12'h014;
    localparam logic [11:0] ADDR_STATUS    = 12'h018;
    localparam logic [11:0] ADDR_LATCH_CLR = 12'h01C;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_TSEL_LSB   = 0;
    localparam int CTRL_TMODE_LSB  = 4;
    localparam int CTRL_TNC_BIT    = 8;
    localparam int CTRL_DMODE_LSB  = 12;
    localparam int CTRL_DSW_EN_BIT = 16;
    localparam int CTRL_DSW_LSB    = 20;
    localparam int RSEL_W          = 4;
    localparam int HI_LSB          = 16;
    localparam int ST_AUX_LSB      = 0;
    localparam int ST_TOUT_BIT     = 4;
    localparam int ST_START_BIT    = 5;
    localparam int ST_DFAULT_BIT   = 6;
    localparam int ST_LATCH_BIT    = 7;
    localparam int ST_SEQ_LSB      = 8;
    localparam int LATCH_CLR_BIT   = 0;

    // ----------------------------------------
    // reset values and limits
    // ----------------------------------------
    localparam logic [12:0] TIMER_SET_RST = 13'h001E;
    localparam logic [12:0] TIMER_SET_MAX = 13'h1770;
    localparam logic [15:0] DMPR_TIME_RST = 16'h001E;
    localparam logic [11:0] VIN_FULL      = 12'hFFF;
    localparam int          NUM_INPUTS    = 7;
    localparam int          NUM_RELAYS    = 4;

    // ----------------------------------------
    // modes and functions
    // ----------------------------------------
    typedef enum logic [1:0] {
        TM_ON_DELAY,
        TM_OFF_DELAY,
        TM_ONE_PULSE,
        TM_SYMM
    } arft_tmode_t;

    typedef enum logic [1:0] {
        DM_NONE,
        DM_DAMPER,
        DM_LUBE
    } arft_dmode_t;

    typedef enum logic [3:0] {
        FN_NONE,
        FN_REF_REACHED,
        FN_AT_SETPOINT,
        FN_IN_RANGE,
        FN_ABOVE_FREQ,
        FN_BELOW_FREQ,
        FN_OVERLOAD,
        FN_RUN,
        FN_STOP,
        FN_DAMPER,
        FN_LUBE_ONLY,
        FN_LUBE_REFILL,
        FN_TIMER,
        FN_VIN_SAT,
        FN_LOSS_LATCH
    } arft_func_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT,
        SEQ_RUN,
        SEQ_FAULT
    } arft_seq_t;
endpackage
`default_nettype wire

/* verif/arft_chk.sv */
// port assertions for the relay function timer block
`default_nettype none
module arft_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        start_request,
    input wire logic        motor_start,
    input wire logic        damper_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic setup;
    assign setup = psel && !penable;
    a_ready_setup: assert property (setup |=> pready) else $error("ready missing");
    a_ready_only: assert property (!setup |=> !pready) else $error("stray ready");
    a_err_misalign: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("no error on misaligned address");
    a_ok_mapped: assert property (setup && paddr[1:0] == 2'h0 && paddr <= 12'h01C |=> !pslverr)
        else $error("error on mapped address");
    a_data_quiet: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0000_0000)
        else $error("read data on write or error");
    a_fault_nomotor: assert property (damper_fault |-> !motor_start)
        else $error("motor runs during damper fault");
    a_drop_idle: assert property (!start_request |=> !motor_start && !damper_fault)
        else $error("sequence outlives start request");
    a_motor_cause: assert property ($rose(motor_start) |-> $past(start_request))
        else $error("motor started without request");
endmodule
bind arft_top arft_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_request(start_request), .motor_start(motor_start), .damper_fault(damper_fault));
`default_nettype wire

/* verif/arft_damper_act.sv */
// damper actuator with end switch on the relay's far side
`default_nettype none
module arft_damper_act #(
    parameter int STROKE = 8
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic coil,
    input  wire logic healthy,
    output logic      end_sw
);
    timeunit 1ns;
    timeprecision 1ps;
    int travel;
    // switch makes only after full travel; a jammed blade never makes it
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn || !coil || !healthy)
            travel <= 0;
        else if (travel < STROKE)
            travel <= travel + 1;
    end
    assign end_sw = (travel == STROKE);
endmodule
`default_nettype wire

/* verif/aux_relay_function_timer_tb.sv */
// self-checking bench for the relay function timer block
`default_nettype none
module aux_relay_function_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        trig = 1'b0, start_request = 1'b0, drive_stopped = 1'b1, loss = 1'b0;
    logic        healthy = 1'b1, end_sw, pready, pslverr, motor_start, damper_fault, err;
    logic [11:0] paddr = 12'h000, vin = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  aux_relay;
    logic [15:0] sref = 16'h0000, fout = 16'h0000, iout = 16'h0000;
    int          num_errors = 0, compares = 0, rises, highs;
    always #2.5 pclk = ~pclk;
    arft_top #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .multi_function_inputs({5'h00, end_sw, trig}),
        .start_request(start_request), .drive_stopped(drive_stopped), .speed_ref(sref),
        .out_freq(fout), .out_current(iout), .voltage_analog_input(vin),
        .current_input_loss_trip(loss), .aux_relay(aux_relay), .motor_start(motor_start),
        .damper_fault(damper_fault));
    arft_damper_act u_act (.clk(pclk), .rstn(presetn), .coil(aux_relay[1]),
        .healthy(healthy), .end_sw(end_sw));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // edges and high time of the timer relay over a window
    task automatic watch(input int n);
        logic prev;
        prev = aux_relay[0];
        {rises, highs} = 0;
        repeat (n)
        begin
            @(posedge pclk);
            rises += int'(aux_relay[0] && !prev);
            highs += int'(aux_relay[0]);
            prev = aux_relay[0];
        end
    endtask
    task automatic frequency_detection(input logic [15:0] f, input logic [3:0] e);
        fout <= f;
        ticks(3);
        check("fdt relays", {28'h0, aux_relay}, {28'h0, e});
    endtask
    task automatic test_done;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        ticks(6000);
        num_errors++;
        test_done;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        ticks(5);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        check("timer set rst", rd, 32'h0000_001E);
        apb(1'b0, 12'h008, 32'h0);
        check("delay rst", rd, 32'h0000_001E);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl rst", rd, 32'h0000_0000);
        apb(1'b1, 12'h004, 32'h0000_1B58);
        apb(1'b0, 12'h004, 32'h0);
        check("timer set max", rd, 32'h0000_1770);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", {31'h0, err}, 32'h1);
        vin <= 12'hFFF;
        ticks(6);
        check("relays none", {28'h0, aux_relay}, 32'h0);
        // timer, damper, full-scale, loss latch on relays 0..3
        apb(1'b1, 12'h00C, 32'h0000_ED9C);
        ticks(4);
        check("vin sat", {31'h0, aux_relay[2]}, 32'h1);
        {vin, loss} <= {12'hFFE, 1'b1};
        ticks(3);
        loss <= 1'b0;
        ticks(4);
        check("vin clear", {31'h0, aux_relay[2]}, 32'h0);
        check("loss held", {31'h0, aux_relay[3]}, 32'h1);
        apb(1'b1, 12'h01C, 32'h0000_0001);
        ticks(3);
        check("loss clear", {31'h0, aux_relay[3]}, 32'h0);
        apb(1'b1, 12'h004, 32'h0000_0002);
        apb(1'b1, 12'h000, 32'h0000_0020);
        trig <= 1'b1;
        ticks(3);
        trig <= 1'b0;
        watch(60);
        check("short trig pulses", rises, 1);
        check("pulse len", int'(highs >= TK && highs <= 2 * TK + 4), 1);
        trig <= 1'b1;
        watch(60);
        check("held trig pulses", rises, 1);
        trig <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000_0130);
        watch(100);
        check("nc symm running", int'(rises >= 2 && highs >= 30), 1);
        trig <= 1'b1;
        ticks(30);
        watch(60);
        check("nc symm stopped", rises + highs, 0);
        apb(1'b1, 12'h008, 32'h0000_0005);
        apb(1'b1, 12'h000, 32'h0011_1000);
        repeat (2)
        begin
            {start_request, drive_stopped} <= 2'b10;
            ticks(4);
            check("damper closes", {30'h0, aux_relay[1], motor_start}, 32'h2);
            ticks(26);
            check("motor on switch", {31'h0, motor_start}, 32'h1);
            check("on delay", {31'h0, aux_relay[0]}, 32'h1);
            start_request <= 1'b0;
            ticks(4);
            check("damper held", {31'h0, aux_relay[1]}, 32'h1);
            drive_stopped <= 1'b1;
            ticks(4);
            check("damper open", {31'h0, aux_relay[1]}, 32'h0);
        end
        {start_request, drive_stopped, healthy} <= 3'b100;
        ticks(70);
        check("damper fault", {30'h0, damper_fault, motor_start}, 32'h2);
        {start_request, healthy} <= 2'b01;
        ticks(4);
        check("fault cleared", {31'h0, damper_fault}, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_2000);
        apb(1'b1, 12'h00C, 32'h0000_00BA);
        start_request <= 1'b1;
        ticks(4);
        check("lube wait", {29'h0, aux_relay[1:0], motor_start}, 32'h6);
        ticks(56);
        check("lube refill", {29'h0, aux_relay[1:0], motor_start}, 32'h5);
        ticks(55);
        check("refill done", {29'h0, aux_relay[1:0], motor_start}, 32'h1);
        start_request <= 1'b0;
        apb(1'b1, 12'h00C, 32'h0000_1354);
        apb(1'b1, 12'h010, 32'h0014_0064);
        sref <= 16'h0064;
        frequency_detection(16'h0000, 4'h2);
        frequency_detection(16'h005F, 4'hE);
        frequency_detection(16'h0064, 4'hD);
        frequency_detection(16'h005B, 4'hD);
        frequency_detection(16'h0059, 4'h2);
        apb(1'b1, 12'h00C, 32'h0000_6000);
        apb(1'b1, 12'h014, 32'h0003_0032);
        iout <= 16'h0033;
        ticks(15);
        check("ol early", {28'h0, aux_relay}, 32'h0);
        ticks(20);
        check("ol warn", {28'h0, aux_relay}, 32'h8);
        test_done;
    end
endmodule
`default_nettype wire
